// ===== verilog/ecpx_regs.vh
// Constants for the extended configuration and demand DMA pacing block.
// Assumes an 8-bit register port with a 3-bit address, 100 MHz clock.
`ifndef ECPX_REGS_VH
`define ECPX_REGS_VH
// ==========================================================
// Host port addresses
`define ECPX_A_DATA 3'h0
`define ECPX_A_CTRL 3'h1
`define ECPX_A_STAT 3'h2
`define ECPX_A_CFGA 3'h3
`define ECPX_A_CFGB 3'h4
`define ECPX_A_INDEX 3'h5
`define ECPX_A_IDATA 3'h6
`define ECPX_A_AUX 3'h7
// ==========================================================
// Second-level indices and reset values
`define ECPX_IX_CTLA 3'h0
`define ECPX_IX_CTLB 3'h2
`define ECPX_IX_FAIR 3'h4
`define ECPX_IX_PCFG 3'h5
`define ECPX_CTLA_RST 8'h00
`define ECPX_CTLB_RST 8'h00
`define ECPX_FAIR_RST 8'h07
`define ECPX_PCFG_RST 8'h00
`define ECPX_AUX_RST 8'h00
// ==========================================================
// Mode codes
`define ECPX_M_STD 3'h0
`define ECPX_M_BIDIR 3'h1
`define ECPX_M_PFIFO 3'h2
`define ECPX_M_ECP 3'h3
`define ECPX_M_EPP 3'h4
`define ECPX_M_TEST 3'h6
`define ECPX_M_CFG 3'h7
// ==========================================================
// Field positions and fixed field values
`define ECPX_CTLA_TMO 0
`define ECPX_CTLA_FRZ 4
`define ECPX_CTLA_LIVE 5
`define ECPX_CTLB_V19 4
`define ECPX_CTLB_CHAN 6
`define ECPX_CTLB_COMPAT 7
`define ECPX_PCFG_PE 2
`define ECPX_PCFG_DEMAND 6
`define ECPX_PCFG_USER 7
`define ECPX_PCR_IRQEN 4
`define ECPX_PCR_DIR 5
`define ECPX_STAT_IRQ 2
`define ECPX_CFGA_HI 4'h1
`define ECPX_CFGA_LO 3'h4
// ==========================================================
// Pacing and timing
`define ECPX_BURST 3'h4
`define ECPX_ACT_STEP 6'h04
`define ECPX_INACT_BASE 8'h08
`define ECPX_INACT_STEP 8'h20
`define ECPX_CLK_MHZ 7'h64
`define ECPX_FLUSH_MHZ 7'h18
`define ECPX_FLUSH_LAST 8'hff
`endif

// ===== verilog/ecpx_top.v
// Extended configuration bank, register read paths and demand DMA pacing.
// Assumes the FIFO, cycle engine and mode register live outside and that
// every input is synchronous to clk.
`timescale 1ns/1ns
`include "ecpx_regs.vh"
module ecpx_top (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host register port
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  // Configuration and mode context
  input wire ext_cfg_enable,
  input wire [2:0] mode_sel,
  input wire [7:0] port_control_reg,
  input wire [3:0] ctrl_pins,
  input wire [7:0] port_data_reg,
  input wire [7:0] data_pins,
  input wire [7:0] status_pins,
  input wire irq_line_level,
  input wire irq_req,
  input wire ack_n,
  // FIFO and peripheral engine
  input wire fifo_bottom_tag,
  input wire fifo_full,
  input wire fifo_empty,
  input wire fifo_free_ge4,
  input wire fifo_valid_ge4,
  input wire byte_arrived,
  input wire cmd_valid,
  input wire periph_busy,
  input wire [7:0] periph_data,
  output reg cmd_to_fifo_ff,
  output reg freeze_ff,
  output reg periph_init_ff,
  // Mode and option outputs
  output reg [6:0] mode_onehot_ff,
  output reg epp_tmo_en_ff,
  output reg epp_v19_ff,
  output reg pe_pullup_ff,
  output reg dir_bwd_ff,
  // DMA
  input wire dma_go,
  input wire dma_req,
  input wire dma_xfer,
  output reg drq_ff,
  // Interrupt pin
  output reg port_interrupt_out_ff,
  output reg port_interrupt_oe_ff
);

localparam S_IDLE = 1'b0;
localparam S_BURST = 1'b1;

// ==========================================================
// Helpers
function [5:0] act_limit;
  input [2:0] n;
  begin
    if (n == 3'h0)
      act_limit = 6'h01;
    else
      act_limit = `ECPX_ACT_STEP * ({3'h0, n} + 6'h01);
  end
endfunction

function [7:0] inact_limit;
  input [2:0] n;
  begin
    inact_limit = `ECPX_INACT_BASE + `ECPX_INACT_STEP * {5'h00, n};
  end
endfunction

function is_mode;
  input [2:0] m;
  input [2:0] code;
  begin
    is_mode = (m == code);
  end
endfunction

// ==========================================================
// Storage
reg [2:0] index_ff;
reg [7:0] ctla_ff;
reg [7:0] ctlb_ff;
reg [7:0] fair_ff;
reg [7:0] pcfg_ff;
reg ack_flag_ff;
reg ack_prev_ff;
reg [2:0] mode_prev_ff;
reg state_ff;
reg [5:0] act_cnt_ff;
reg [2:0] burst_ff;
reg [7:0] hold_ff;
reg [6:0] acc_ff;
reg flush_run_ff;
reg [7:0] flush_cnt_ff;
reg flush_hit_ff;

// ==========================================================
// Mode decode and context
wire m_std = is_mode(mode_sel, `ECPX_M_STD);
wire m_bidir = is_mode(mode_sel, `ECPX_M_BIDIR);
wire m_pfifo = is_mode(mode_sel, `ECPX_M_PFIFO);
wire m_ecp = is_mode(mode_sel, `ECPX_M_ECP);
wire m_epp = is_mode(mode_sel, `ECPX_M_EPP);
wire m_test = is_mode(mode_sel, `ECPX_M_TEST);
wire m_cfg = is_mode(mode_sel, `ECPX_M_CFG);
// Direction is forced forward in 000 and 010
wire bwd = port_control_reg[`ECPX_PCR_DIR] & ~m_std & ~m_pfifo;
wire compat = ctlb_ff[`ECPX_CTLB_COMPAT];
wire legacy = m_std | m_bidir | m_epp;
wire mode_chg = (mode_prev_ff != mode_sel);
wire demand = pcfg_ff[`ECPX_PCFG_DEMAND];
wire sel_ok = ext_cfg_enable;
wire ix_wr = reg_wr & sel_ok & (reg_addr == `ECPX_A_INDEX);
wire dt_wr = reg_wr & sel_ok & (reg_addr == `ECPX_A_IDATA);
wire st_rd = reg_rd & (reg_addr == `ECPX_A_STAT);
wire ack_trail = ~ack_prev_ff & ack_n;

// ==========================================================
// Second-level registers
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    index_ff <= 3'h0;
    ctla_ff <= `ECPX_CTLA_RST;
    ctlb_ff <= `ECPX_CTLB_RST;
    fair_ff <= `ECPX_FAIR_RST;
    pcfg_ff <= `ECPX_PCFG_RST;
  end
  else
  begin
    if (ix_wr)
      index_ff <= reg_wdata[2:0];
    if (dt_wr)
    begin
      case (index_ff)
        `ECPX_IX_CTLA: ctla_ff <= reg_wdata;
        `ECPX_IX_CTLB: ctlb_ff <= reg_wdata;
        `ECPX_IX_FAIR: fair_ff <= reg_wdata;
        `ECPX_IX_PCFG: pcfg_ff <= reg_wdata;
        default: ;
      endcase
    end
  end
end

// ==========================================================
// Read paths
reg [7:0] idata_rd;
reg [7:0] ctrl_rd;
reg [7:0] data_rd;
reg [7:0] stat_rd;
reg [7:0] nxt_rdata;

always @*
begin
  case (index_ff)
    `ECPX_IX_CTLA: idata_rd = ctla_ff;
    `ECPX_IX_CTLB: idata_rd = ctlb_ff;
    `ECPX_IX_FAIR: idata_rd = fair_ff;
    `ECPX_IX_PCFG: idata_rd = pcfg_ff;
    default: idata_rd = 8'h00;
  endcase
  ctrl_rd = port_control_reg;
  if (ctla_ff[`ECPX_CTLA_LIVE] | (compat & legacy))
    ctrl_rd[3:0] = ctrl_pins;
  if (compat & (m_std | m_bidir))
    ctrl_rd[`ECPX_PCR_DIR] = 1'b1;
  if (compat & (m_std | (legacy & ~bwd)))
    data_rd = port_data_reg;
  else
    data_rd = data_pins;
  stat_rd = status_pins;
  if (compat & m_bidir)
    stat_rd[`ECPX_STAT_IRQ] = ack_flag_ff;
  case (reg_addr)
    `ECPX_A_DATA: nxt_rdata = data_rd;
    `ECPX_A_CTRL: nxt_rdata = ctrl_rd;
    `ECPX_A_STAT: nxt_rdata = stat_rd;
    `ECPX_A_CFGA:
      nxt_rdata = {`ECPX_CFGA_HI, pcfg_ff[`ECPX_PCFG_USER],
        `ECPX_CFGA_LO};
    `ECPX_A_CFGB:
      nxt_rdata = {1'b0, irq_line_level, pcfg_ff[5:3], 1'b0,
        pcfg_ff[1:0]};
    `ECPX_A_INDEX: nxt_rdata = sel_ok ? {5'h00, index_ff} : 8'h00;
    `ECPX_A_IDATA: nxt_rdata = sel_ok ? idata_rd : 8'h00;
    `ECPX_A_AUX:
      nxt_rdata = sel_ok ? {fifo_bottom_tag, 7'h00} : 8'h00;
    default: nxt_rdata = 8'h00;
  endcase
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    reg_rdata_ff <= `ECPX_AUX_RST;
  else if (reg_rd)
    reg_rdata_ff <= nxt_rdata;
end

// ==========================================================
// Option outputs, freeze and command capture
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    mode_onehot_ff <= 7'h00;
    epp_tmo_en_ff <= 1'b0;
    epp_v19_ff <= 1'b0;
    pe_pullup_ff <= 1'b0;
    dir_bwd_ff <= 1'b0;
    freeze_ff <= 1'b0;
    periph_init_ff <= 1'b0;
    cmd_to_fifo_ff <= 1'b0;
  end
  else
  begin
    mode_onehot_ff <= {m_cfg, m_test, m_epp, m_ecp, m_pfifo, m_bidir,
      m_std};
    epp_tmo_en_ff <= ctla_ff[`ECPX_CTLA_TMO];
    epp_v19_ff <= ctlb_ff[`ECPX_CTLB_V19];
    pe_pullup_ff <= pcfg_ff[`ECPX_PCFG_PE];
    dir_bwd_ff <= bwd;
    freeze_ff <= m_ecp & ctla_ff[`ECPX_CTLA_FRZ];
    // Clearing the freeze bit in ECP mode restarts the peripheral side cleanly
    periph_init_ff <= freeze_ff & m_ecp & ~ctla_ff[`ECPX_CTLA_FRZ];
    cmd_to_fifo_ff <= ctlb_ff[`ECPX_CTLB_CHAN] & m_ecp & bwd & cmd_valid &
      ~periph_busy & periph_data[7];
  end
end

// ==========================================================
// Interrupt pin in the compatibility variant
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    ack_prev_ff <= 1'b1;
    ack_flag_ff <= 1'b0;
    port_interrupt_out_ff <= 1'b0;
    port_interrupt_oe_ff <= 1'b0;
  end
  else
  begin
    ack_prev_ff <= ack_n;
    // A trailing edge in the clearing read cycle is kept
    if (ack_trail)
      ack_flag_ff <= 1'b1;
    else if (st_rd)
      ack_flag_ff <= 1'b0;
    if (compat & m_bidir)
      port_interrupt_out_ff <= ack_flag_ff | ack_trail;
    else
      port_interrupt_out_ff <= irq_req;
    port_interrupt_oe_ff <= ~(compat & legacy &
      ~port_control_reg[`ECPX_PCR_IRQEN]);
  end
end

// ==========================================================
// 24 MHz tick from the 100 MHz clock by fractional accumulation
// The tick jitters by one clock; only the average rate matters here.
wire [7:0] acc_sum = {1'b0, acc_ff} + {1'b0, `ECPX_FLUSH_MHZ};
wire tick24 = (acc_sum >= {1'b0, `ECPX_CLK_MHZ});

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
    acc_ff <= 7'h00;
  else if (tick24)
    acc_ff <= acc_sum[6:0] - `ECPX_CLK_MHZ;
  else
    acc_ff <= acc_sum[6:0];
end

// ==========================================================
// Flush time-out
wire flush_stop = drq_ff | ~bwd | ~demand | mode_chg;
wire flush_exp = flush_run_ff & tick24 &
  (flush_cnt_ff == `ECPX_FLUSH_LAST);

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    flush_run_ff <= 1'b0;
    flush_cnt_ff <= 8'h00;
    flush_hit_ff <= 1'b0;
  end
  else if (flush_stop)
  begin
    flush_run_ff <= 1'b0;
    flush_cnt_ff <= 8'h00;
    flush_hit_ff <= 1'b0;
  end
  else
  begin
    if (byte_arrived)
      flush_run_ff <= 1'b1;
    if (flush_exp)
    begin
      flush_hit_ff <= 1'b1;
      flush_run_ff <= 1'b0;
      flush_cnt_ff <= 8'h00;
    end
    else if (flush_run_ff & tick24)
      flush_cnt_ff <= flush_cnt_ff + 8'h01;
  end
end

// ==========================================================
// DMA request pacing
wire fair_ok = (hold_ff == 8'h00);
wire want = (bwd ? fifo_valid_ge4 : fifo_free_ge4) | flush_hit_ff;
wire can_xfer = bwd ? ~fifo_empty : ~fifo_full;
wire start = dma_go & fair_ok & (demand ? want : dma_req);
wire [5:0] act_next = act_cnt_ff + 6'h01;
wire [2:0] burst_next = burst_ff + 3'h1;
wire act_full = (act_next >= act_limit(fair_ff[2:0]));
wire lost = ~dma_go | (demand ? ~can_xfer : ~dma_req);

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    state_ff <= S_IDLE;
    drq_ff <= 1'b0;
    act_cnt_ff <= 6'h00;
    burst_ff <= 3'h0;
    hold_ff <= 8'h00;
    mode_prev_ff <= `ECPX_M_STD;
  end
  else
  begin
    mode_prev_ff <= mode_sel;
    if (hold_ff != 8'h00)
      hold_ff <= hold_ff - 8'h01;
    if (mode_chg)
    begin
      // Pacing restarts with the FIFO flush on a mode change
      state_ff <= S_IDLE;
      drq_ff <= 1'b0;
      act_cnt_ff <= 6'h00;
      burst_ff <= 3'h0;
      hold_ff <= 8'h00;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
        begin
          act_cnt_ff <= 6'h00;
          burst_ff <= 3'h0;
          if (start)
          begin
            drq_ff <= 1'b1;
            state_ff <= S_BURST;
          end
        end
        S_BURST:
        begin
          if (dma_xfer & act_full)
          begin
            drq_ff <= 1'b0;
            hold_ff <= inact_limit(fair_ff[6:4]);
            state_ff <= S_IDLE;
          end
          else if (dma_xfer & demand & (burst_next == `ECPX_BURST))
          begin
            act_cnt_ff <= act_next;
            burst_ff <= 3'h0;
            if (~want | ~dma_go)
            begin
              drq_ff <= 1'b0;
              state_ff <= S_IDLE;
            end
          end
          else if (lost)
          begin
            drq_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
          else if (dma_xfer)
          begin
            act_cnt_ff <= act_next;
            burst_ff <= burst_next;
          end
        end
        default:
        begin
          drq_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
end

endmodule // ecpx_top

// ===== testbench/ecpx_chk.sv
// Port checker for the extended config bank and DMA pacing.
// Assumes binding to ecpx_top; all inputs are synchronous to clk.
`timescale 1ns/1ns
module ecpx_chk (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host port and context
  input wire [2:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_ff,
  input wire ext_cfg_enable,
  input wire [2:0] mode_sel,
  input wire [7:0] port_control_reg,
  input wire irq_line_level,
  input wire fifo_bottom_tag,
  input wire cmd_valid,
  input wire periph_busy,
  input wire [7:0] periph_data,
  input wire dma_go,
  // Design outputs
  input wire [6:0] mode_onehot_ff,
  input wire cmd_to_fifo_ff,
  input wire freeze_ff,
  input wire dir_bwd_ff,
  input wire drq_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // =========
  // Helpers
  wire cmd_ok = cmd_valid && !periph_busy && periph_data[7]
    && mode_sel == 3'h3 && port_control_reg[5];
  // =========
  // Assertions
  a_rd_gated: assert property (reg_rd && reg_addr > 3'h4
    && !ext_cfg_enable |=> reg_rdata_ff == 8'h00) else $error("gated read");
  a_index_high: assert property (reg_rd && reg_addr == 3'h5
    |=> reg_rdata_ff[7:3] == 5'h00) else $error("index high bits");
  a_cfga_fixed: assert property (reg_rd && reg_addr == 3'h3 |=>
    reg_rdata_ff[7:4] == 4'h1 && reg_rdata_ff[2:0] == 3'h4)
    else $error("first config fixed bits");
  a_cfgb_irq: assert property (reg_rd && reg_addr == 3'h4 |=>
    {reg_rdata_ff[7:6], reg_rdata_ff[2]} == {1'b0, $past(irq_line_level),
    1'b0}) else $error("second config bits");
  a_aux_tag: assert property (reg_rd && reg_addr == 3'h7 &&
    ext_cfg_enable && mode_sel == 3'h3 && port_control_reg[5] |=>
    reg_rdata_ff[7] == $past(fifo_bottom_tag)) else $error("aux tag");
  a_mode_decode: assert property ($past(rst_n) &&
    $past(mode_sel) != 3'h5 |-> mode_onehot_ff == 7'h01 <<
    ($past(mode_sel) - ($past(mode_sel) > 3'h4))) else $error("mode");
  a_freeze_ecp: assert property (freeze_ff |->
    $past(mode_sel) == 3'h3) else $error("freeze outside ecp mode");
  a_dir_forced: assert property (dir_bwd_ff |->
    $past(port_control_reg[5]) && $past(mode_sel) != 3'h0 &&
    $past(mode_sel) != 3'h2) else $error("direction");
  a_cmd_push: assert property (cmd_to_fifo_ff |->
    $past(cmd_ok)) else $error("command push");
  a_drq_go: assert property (drq_ff |->
    $past(dma_go)) else $error("request without enable");
endmodule // ecpx_chk
bind ecpx_top ecpx_chk u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .ext_cfg_enable(ext_cfg_enable), .mode_sel(mode_sel),
  .port_control_reg(port_control_reg), .irq_line_level(irq_line_level),
  .fifo_bottom_tag(fifo_bottom_tag), .cmd_valid(cmd_valid),
  .periph_busy(periph_busy), .periph_data(periph_data), .dma_go(dma_go),
  .mode_onehot_ff(mode_onehot_ff), .cmd_to_fifo_ff(cmd_to_fifo_ff),
  .freeze_ff(freeze_ff), .dir_bwd_ff(dir_bwd_ff), .drq_ff(drq_ff));

// ===== testbench/ecpx_far.sv
// Far-side DMA controller: one transfer per cycle it grants.
// Assumes the request is a level sampled on the falling edge.
`timescale 1ns/1ns
module ecpx_far (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Request and pacing
  input wire drq_ff,
  input wire slow,
  output wire dma_xfer
);
  reg xfer_ff;
  reg [1:0] wait_ff;
  assign dma_xfer = xfer_ff;
  // Slow mode idles between bus cycles, as a shared bus would
  always @(negedge clk or negedge rst_n)
    if (!rst_n)
    begin
      xfer_ff <= 1'b0;
      wait_ff <= 2'h0;
    end
    else if (xfer_ff)
    begin
      xfer_ff <= 1'b0;
      wait_ff <= slow ? 2'h3 : 2'h0;
    end
    else if (wait_ff != 2'h0)
      wait_ff <= wait_ff - 2'h1;
    else
      xfer_ff <= drq_ff;
endmodule // ecpx_far

// ===== testbench/ecpx_top_tb_top.sv
// Bench for the extended config bank and DMA pacing block.
// Assumes ecpx_top, the map of ecpx_regs.vh and a 100 MHz clock.
`timescale 1ns/1ns
`include "ecpx_regs.vh"
module ecpx_top_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0, ext = 1'b1;
  reg [2:0] addr = 3'h0, mode = 3'h0;
  reg [7:0] wd = 8'h00, pcr = 8'h00, pdr = 8'h00, dpins = 8'h00;
  reg [7:0] stat = 8'h00, pdata = 8'h00, d, f;
  reg [3:0] cpins = 4'h0;
  reg irql = 1'b0, irqr = 1'b0, ack = 1'b1, tag = 1'b0, busy = 1'b0;
  reg free4 = 1'b0, val4 = 1'b0, arr = 1'b0, cmdv = 1'b0;
  reg go = 1'b0, req = 1'b0, slow = 1'b0, man = 1'b0, emp = 1'b0;
  reg [31:0] seed = 32'h00014f7b, x, bg;
  reg [7:0] er [0:3];
  integer mismatches = 0, total_checks = 0, i, j, k, n0, nx = 0;
  wire xfer, drq, tmo, v19, frz, cmdf, pinit, pe, iout, ioe, dirb;
  wire [7:0] rdata;
  wire [6:0] oh;
  always #5 clk = ~clk;
  always @(posedge clk) if (xfer) nx <= nx + 1;
  // =========
  // Design and far side
  ecpx_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd_s), .reg_wdata(wd), .reg_rdata_ff(rdata),
    .ext_cfg_enable(ext), .mode_sel(mode), .port_control_reg(pcr),
    .ctrl_pins(cpins), .port_data_reg(pdr), .data_pins(dpins),
    .status_pins(stat), .irq_line_level(irql), .irq_req(irqr),
    .ack_n(ack), .fifo_bottom_tag(tag), .fifo_full(1'b0),
    .fifo_empty(emp), .fifo_free_ge4(free4), .fifo_valid_ge4(val4),
    .byte_arrived(arr), .cmd_valid(cmdv), .periph_busy(busy),
    .periph_data(pdata), .cmd_to_fifo_ff(cmdf), .freeze_ff(frz),
    .periph_init_ff(pinit), .mode_onehot_ff(oh), .epp_tmo_en_ff(tmo),
    .epp_v19_ff(v19), .pe_pullup_ff(pe), .dir_bwd_ff(dirb), .dma_go(go),
    .dma_req(req), .dma_xfer(xfer), .drq_ff(drq),
    .port_interrupt_out_ff(iout), .port_interrupt_oe_ff(ioe));
  ecpx_far far (.clk(clk), .rst_n(rst_n), .drq_ff(drq), .slow(slow),
    .dma_xfer(xfer));
  // =========
  // Helpers
  function [31:0] rnd();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  end
  endfunction
  function [15:0] act_lim(input [2:0] n);
    act_lim = (n == 3'h0) ? 16'h0001 : 16'h0004 * (n + 16'h0001);
  endfunction
  function [15:0] gap_min(input [2:0] n);
    gap_min = 16'h0008 + 16'h0020 * n;
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  task wrb(input [2:0] a, input [7:0] v);
  begin
    @(negedge clk);
    {addr, wd, wr} = {a, v, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  end
  endtask
  task rdb(input [2:0] a, output [7:0] v);
  begin
    @(negedge clk);
    {addr, rd_s} = {a, 1'b1};
    @(negedge clk);
    rd_s = 1'b0;
    v = rdata;
  end
  endtask
  task iwr(input [2:0] ix, input [7:0] v);
  begin
    wrb(`ECPX_A_INDEX, {5'h00, ix});
    wrb(`ECPX_A_IDATA, v);
  end
  endtask
  task ird(input [2:0] ix, output [7:0] v);
  begin
    wrb(`ECPX_A_INDEX, {5'h00, ix});
    rdb(`ECPX_A_IDATA, v);
  end
  endtask
  task till(input lvl);
  begin
    k = 0;
    while (drq !== lvl && k < 2000)
    begin
      @(negedge clk);
      k = k + 1;
    end
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Background pins keep changing so nothing passes on a stale value,
  // until a scenario takes them over by hand
  always @(negedge clk)
    if (!man)
    begin
      bg = rnd();
      {stat, irqr, ack, tag, cmdv, busy, pdata} = bg[20:0];
    end
  initial
  begin
    #200000;
    mismatches = mismatches + 1;
    test_done;
  end
  // =========
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      ird((i == 3) ? 3'h5 : {i[1:0], 1'b0}, d);
      chk(d, (i == 2) ? 8'h07 : 8'h00);
      x = rnd();
      er[i] = x[7:0];
      iwr((i == 3) ? 3'h5 : {i[1:0], 1'b0}, er[i]);
    end
    for (j = 1; j < 8; j = j + 1)
      if (j != 2 && j != 4 && j != 5)
      begin
        iwr(j[2:0], 8'hff);
        ird(j[2:0], d);
        chk(d, 8'h00);
      end
    for (i = 0; i < 4; i = i + 1)
    begin
      ird((i == 3) ? 3'h5 : {i[1:0], 1'b0}, d);
      chk(d, er[i]);
    end
    wrb(`ECPX_A_INDEX, 8'hfd);
    rdb(`ECPX_A_INDEX, d);
    chk(d, 8'h05);
    rdb(`ECPX_A_IDATA, d);
    chk(d, er[3]);
    rdb(`ECPX_A_CFGA, d);
    chk(d, {4'h1, er[3][7], 3'h4});
    chk(pe, er[3][2]);
    irql = 1'b1;
    rdb(`ECPX_A_CFGB, d);
    chk(d, {2'h1, er[3][5:3], 1'b0, er[3][1:0]});
    ext = 1'b0;
    iwr(3'h0, ~er[0]);
    ird(3'h0, d);
    chk(d, 8'h00);
    ext = 1'b1;
    ird(3'h0, d);
    chk(d, er[0]);
    iwr(3'h0, 8'h01);
    iwr(3'h2, 8'h10);
    @(negedge clk);
    chk({tmo, v19}, 2'h3);
    iwr(3'h0, 8'h00);
    iwr(3'h2, 8'h00);
    @(negedge clk);
    chk({tmo, v19}, 2'h0);
    for (j = 0; j < 8; j = j + 1)
      if (j != 5)
      begin
        mode = j[2:0];
        @(negedge clk);
        chk(oh, 7'h01 << (j - (j > 4)));
      end
    mode = 3'h3;
    iwr(3'h0, 8'h10);
    @(negedge clk);
    chk(frz, 1'b1);
    iwr(3'h0, 8'h00);
    @(negedge clk);
    chk(pinit, 1'b1);
    @(negedge clk);
    chk({frz, pinit}, 2'h0);
    iwr(3'h0, 8'h10);
    mode = 3'h0;
    repeat (2) @(negedge clk);
    chk(frz, 1'b0);
    x = rnd();
    {pcr, cpins, pdr} = x[19:0];
    dpins = ~pdr;
    mode = 3'h2;
    iwr(3'h0, 8'h20);
    rdb(`ECPX_A_CTRL, d);
    chk(d, {pcr[7:4], cpins});
    iwr(3'h0, 8'h00);
    rdb(`ECPX_A_CTRL, d);
    chk(d, pcr);
    iwr(3'h2, 8'h80);
    mode = 3'h1;
    rdb(`ECPX_A_CTRL, d);
    chk(d, {pcr[7:6], 1'b1, pcr[4], cpins});
    mode = 3'h0;
    rdb(`ECPX_A_DATA, d);
    chk(d, pdr);
    iwr(3'h2, 8'h00);
    iwr(3'h5, 8'h00);
    // Fairness: burst length and enforced idle gap per setting
    {mode, pcr, req} = {3'h3, 8'h00, 1'b1};
    for (i = 0; i < 3; i = i + 1)
    begin
      f = (i == 0) ? 8'h00 : (i == 1) ? 8'h11 : 8'h27;
      iwr(3'h4, f);
      {slow, go} = {i[0], 1'b1};
      till(1'b1);
      n0 = nx;
      till(1'b0);
      chk(nx - n0, act_lim(f[2:0]));
      till(1'b1);
      chk(k >= gap_min(f[6:4]), 16'h0001);
      go = 1'b0;
      repeat (300) @(negedge clk);
    end
    // Demand threshold, four-transfer hold, then flush expiry
    iwr(3'h4, 8'h07);
    iwr(3'h5, 8'h40);
    {req, free4, go} = 3'h3;
    till(1'b1);
    chk(k < 4, 16'h0001);
    n0 = nx;
    free4 = 1'b0;
    till(1'b0);
    chk(nx - n0, 16'h0004);
    pcr = 8'h20;
    repeat (20) @(negedge clk);
    arr = 1'b1;
    @(negedge clk);
    arr = 1'b0;
    repeat (1000) @(negedge clk);
    chk(drq, 1'b0);
    till(1'b1);
    chk(k < 150, 16'h0001);
    emp = 1'b1;
    @(negedge clk);
    chk(drq, 1'b0);
    {emp, go} = 2'h0;
    // Pin-side options with the background held still
    man = 1'b1;
    tag = 1'b1;
    rdb(`ECPX_A_AUX, d);
    chk(d, 8'h80);
    chk(dirb, 1'b1);
    tag = 1'b0;
    rdb(`ECPX_A_AUX, d);
    chk(d, 8'h00);
    iwr(3'h2, 8'h40);
    {cmdv, busy, pdata} = {2'h2, 8'h80};
    @(negedge clk);
    chk(cmdf, 1'b1);
    pdata = 8'h7f;
    @(negedge clk);
    chk(cmdf, 1'b0);
    cmdv = 1'b0;
    iwr(3'h2, 8'h80);
    {mode, pcr, ack} = {3'h1, 8'h00, 1'b1};
    @(negedge clk);
    chk(ioe, 1'b0);
    pcr = 8'h10;
    @(negedge clk);
    chk(ioe, 1'b1);
    rdb(`ECPX_A_STAT, d);
    @(negedge clk);
    chk(iout, 1'b0);
    ack = 1'b0;
    @(negedge clk);
    ack = 1'b1;
    @(negedge clk);
    chk(iout, 1'b1);
    rdb(`ECPX_A_STAT, d);
    chk(d[2], 1'b1);
    @(negedge clk);
    chk(iout, 1'b0);
    test_done;
  end
endmodule // ecpx_top_tb_top
